// >>> common/gdhs_pkg.sv
// package: register map, field layout and reset values for the high-side drive config bank
package gdhs_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 11;

    // register addresses of the configuration space
    localparam logic [3:0] DRV_CTRL_ADDR = 4'h2;
    localparam logic [3:0] HS_CFG_ADDR   = 4'h3;

    // high-side drive config field positions
    localparam int LOCK_MSB = 10;
    localparam int LOCK_LSB = 8;
    localparam int SRC_MSB  = 7;
    localparam int SRC_LSB  = 4;
    localparam int SNK_MSB  = 3;
    localparam int SNK_LSB  = 0;

    // driver control action bits
    localparam int CLR_BIT   = 0;
    localparam int BRAKE_BIT = 1;
    localparam int COAST_BIT = 2;

    // lock codes and reset values
    localparam logic [2:0]  LOCK_CODE       = 3'h6;
    localparam logic [2:0]  UNLOCK_CODE     = 3'h3;
    localparam logic [3:0]  SRC_RST         = 4'hf;
    localparam logic [3:0]  SNK_RST         = 4'hf;
    localparam logic [10:0] DRV_CTRL_RST    = 11'h000;

    // one register access from the serial port front end
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } gdhs_req_t;

    // settings applied to the gate drivers
    typedef struct packed {
        logic [3:0] src_code;
        logic [3:0] snk_code;
        logic [9:0] src_ma;
        logic       brake;
        logic       coast;
    } gdhs_drive_t;
endpackage

// >>> verilog/gdhs_config_lock.sv
// high-side gate drive config register with write lock and driver control action bits
//
// Operation
// - lock code 110b blocks other writes except the brake, coast and clear-fault bits
// - unlocked, other lock codes leave the lock off; the source and sink codes are still written
// - code 011b unlocks; lock resets to 011b
// - locked, codes other than 011b ignored
// - source code bits 7-4, reset 1111b, monotonic
// - this register sits at address 0x03
// - clear-fault bit writable locked, self-clears
`timescale 1ns/1ps
`default_nettype none

module gdhs_config_lock (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    // register access from the serial port
    input  wire gdhs_pkg::gdhs_req_t  i_req,
    output logic [10:0]               o_rdata,
    output logic                      o_rvalid,
    // write strobe passed on to registers held elsewhere
    output logic                      o_ext_wr,
    output logic [3:0]                o_ext_addr,
    output logic [10:0]               o_ext_data,
    // device state
    output logic                      o_locked,
    output logic                      o_clear_faults,
    output gdhs_pkg::gdhs_drive_t     o_drive
);
    import gdhs_pkg::*;

    // source current in mA per code; only ever rises with the code
    function automatic logic [9:0] src_ma(input logic [3:0] code);
        case (code)
            4'h0:    src_ma = 10'h00a;
            4'h1:    src_ma = 10'h01e;
            4'h2:    src_ma = 10'h03c;
            4'h3:    src_ma = 10'h050;
            4'h4:    src_ma = 10'h078;
            4'h5:    src_ma = 10'h08c;
            4'h6:    src_ma = 10'h0aa;
            4'h7:    src_ma = 10'h0be;
            4'h8:    src_ma = 10'h104;
            4'h9:    src_ma = 10'h14a;
            4'ha:    src_ma = 10'h172;
            4'hb:    src_ma = 10'h1b8;
            4'hc:    src_ma = 10'h23a;
            4'hd:    src_ma = 10'h2a8;
            4'he:    src_ma = 10'h334;
            default: src_ma = 10'h3e8;
        endcase
    endfunction

    logic        locked_reg,   locked_next;
    logic [3:0]  src_reg,      src_next;
    logic [3:0]  snk_reg,      snk_next;
    logic [10:0] ctrl_reg,     ctrl_next;
    logic        clr_reg,      clr_next;
    logic [10:0] rdata_reg,    rdata_next;
    logic        rvalid_reg,   rvalid_next;
    logic        ext_wr_reg,   ext_wr_next;
    logic [3:0]  ext_addr_reg, ext_addr_next;
    logic [10:0] ext_data_reg, ext_data_next;
    logic [2:0]  wr_lock;
    logic        wr_hs_cfg;
    logic        wr_drv_ctrl;
    logic        wr_outside;

    // decode of the write presented this cycle
    assign wr_lock     = i_req.data[LOCK_MSB:LOCK_LSB];
    assign wr_hs_cfg   = i_req.wr && (i_req.addr == HS_CFG_ADDR);
    assign wr_drv_ctrl = i_req.wr && (i_req.addr == DRV_CTRL_ADDR);
    assign wr_outside  = i_req.wr && !wr_hs_cfg && !wr_drv_ctrl;

    // lock state
    always_comb begin
        locked_next = locked_reg;
        if (wr_hs_cfg) begin
            // lock field is always writable; codes outside the pair do nothing
            if (!locked_reg && wr_lock == LOCK_CODE) begin
                locked_next = 1'b1;
            end
            if (locked_reg && wr_lock == UNLOCK_CODE) begin
                locked_next = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            locked_reg <= 1'b0;
        end else begin
            locked_reg <= locked_next;
        end
    end

    // drive codes; gated by the old lock state, so a locking write still lands them
    always_comb begin
        src_next = src_reg;
        snk_next = snk_reg;
        if (wr_hs_cfg && !locked_reg) begin
            src_next = i_req.data[SRC_MSB:SRC_LSB];
            snk_next = i_req.data[SNK_MSB:SNK_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            src_reg <= SRC_RST;
            snk_reg <= SNK_RST;
        end else begin
            src_reg <= src_next;
            snk_reg <= snk_next;
        end
    end

    // driver control bits
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_drv_ctrl) begin
            // action bits stay live under lock so a locked part can still be stopped
            ctrl_next[COAST_BIT] = i_req.data[COAST_BIT];
            ctrl_next[BRAKE_BIT] = i_req.data[BRAKE_BIT];
            if (!locked_reg) begin
                ctrl_next[10:3] = i_req.data[10:3];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_reg <= DRV_CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // clear-fault pulse; never stored, so it returns to 0 by itself
    always_comb begin
        clr_next = wr_drv_ctrl && i_req.data[CLR_BIT];
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            clr_reg <= 1'b0;
        end else begin
            clr_reg <= clr_next;
        end
    end

    // writes for registers held elsewhere, passed on only while unlocked
    always_comb begin
        ext_wr_next   = 1'b0;
        ext_addr_next = ext_addr_reg;
        ext_data_next = ext_data_reg;
        if (wr_outside && !locked_reg) begin
            ext_wr_next   = 1'b1;
            ext_addr_next = i_req.addr;
            ext_data_next = i_req.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ext_wr_reg   <= 1'b0;
            ext_addr_reg <= 4'h0;
            ext_data_reg <= 11'h000;
        end else begin
            ext_wr_reg   <= ext_wr_next;
            ext_addr_reg <= ext_addr_next;
            ext_data_reg <= ext_data_next;
        end
    end

    // read strobe
    always_comb begin
        rvalid_next = i_req.rd;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rvalid_next;
        end
    end

    // read data; a read beside a write in one cycle sees the state before that write
    always_comb begin
        rdata_next = rdata_reg;
        if (i_req.rd) begin
            case (i_req.addr)
                HS_CFG_ADDR: begin
                    rdata_next = {(locked_reg ? LOCK_CODE : UNLOCK_CODE), src_reg, snk_reg};
                end
                DRV_CTRL_ADDR: begin
                    // clear bit always reads back 0
                    rdata_next = {ctrl_reg[10:1], 1'b0};
                end
                default: begin
                    rdata_next = 11'h000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_reg <= 11'h000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata          = rdata_reg;
    assign o_rvalid         = rvalid_reg;
    assign o_ext_wr         = ext_wr_reg;
    assign o_ext_addr       = ext_addr_reg;
    assign o_ext_data       = ext_data_reg;
    assign o_locked         = locked_reg;
    assign o_clear_faults   = clr_reg;
    assign o_drive.src_code = src_reg;
    assign o_drive.snk_code = snk_reg;
    assign o_drive.src_ma   = src_ma(src_reg);
    assign o_drive.brake    = ctrl_reg[BRAKE_BIT];
    assign o_drive.coast    = ctrl_reg[COAST_BIT];

endmodule

`default_nettype wire

// >>> tb/gdhs_monitor.sv
// checker for lock state, drive codes and action pulses of the config bank
`timescale 1ns/1ps
`default_nettype none
module gdhs_monitor import gdhs_pkg::*; (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire gdhs_req_t   i_req,
    input wire logic [10:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        o_ext_wr,
    input wire logic        o_locked,
    input wire logic        o_clear_faults,
    input wire gdhs_drive_t o_drive
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire       w3  = i_req.wr && i_req.addr == HS_CFG_ADDR;
    wire [2:0] lk  = i_req.data[10:8];
    wire       clr = i_req.wr && i_req.addr == DRV_CTRL_ADDR && i_req.data[0];
    wire       wx  = i_req.wr && i_req.addr != DRV_CTRL_ADDR && i_req.addr != HS_CFG_ADDR;
    property p_lock; w3 && lk == LOCK_CODE |=> o_locked; endproperty
    a_lock: assert property (p_lock) else $error("lock not taken");
    property p_ext; wx |=> o_ext_wr == !$past(o_locked); endproperty
    a_ext: assert property (p_ext) else $error("outside write gating");
    property p_stay; !o_locked && !(w3 && lk == LOCK_CODE) |=> !o_locked; endproperty
    a_stay: assert property (p_stay) else $error("locked by other code");
    property p_unl; w3 && lk == UNLOCK_CODE |=> !o_locked; endproperty
    a_unl: assert property (p_unl) else $error("unlock not taken");
    property p_hold; o_locked && !(w3 && lk == UNLOCK_CODE) |=> o_locked; endproperty
    a_hold: assert property (p_hold) else $error("unlocked by other code");
    property p_code; !o_locked && w3 |=> {o_drive.src_code, o_drive.snk_code} ==
        $past(i_req.data[7:0]); endproperty
    a_code: assert property (p_code) else $error("codes not stored");
    property p_frz; o_locked && w3 |=> $stable(o_drive.src_code) && $stable(o_drive.snk_code);
    endproperty
    a_frz: assert property (p_frz) else $error("codes changed while locked");
    property p_clr; clr |=> o_clear_faults ##1 o_clear_faults == $past(clr); endproperty
    a_clr: assert property (p_clr) else $error("clear pulse wrong");
    property p_rd; i_req.rd && i_req.addr == HS_CFG_ADDR |=> o_rvalid && o_rdata ==
        {$past(o_locked) ? LOCK_CODE : UNLOCK_CODE, $past(o_drive.src_code),
        $past(o_drive.snk_code)}; endproperty
    a_rd: assert property (p_rd) else $error("read of config wrong");
endmodule
bind gdhs_config_lock gdhs_monitor gdhs_monitor_i (.i_clk, .i_sys_rst, .i_req, .o_rdata,
    .o_rvalid, .o_ext_wr, .o_locked, .o_clear_faults, .o_drive);
`default_nettype wire

// >>> tb/gdhs_host_model.sv
// host model: presents one-cycle register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module gdhs_host_model (
    input  wire logic              i_clk,
    output var gdhs_pkg::gdhs_req_t o_req
);
    initial o_req = '0;
    // data is scrambled once released so nothing relies on a stale value
    task automatic put(input logic w, r, input logic [3:0] a, input logic [10:0] d);
        @(negedge i_clk);
        o_req = {w, r, a, d};
        @(negedge i_clk);
        o_req = {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// >>> tb/gdhs_config_lock_bench.sv
// bench: register accesses to the high-side drive config bank
`timescale 1ns/1ps
`default_nettype none
module gdhs_config_lock_bench;
    import gdhs_pkg::*;
    logic        i_clk = 0;
    logic        i_sys_rst = 1;
    gdhs_req_t   req;
    logic [10:0] rdata;
    logic        rvalid, ext_wr, locked, clr;
    logic [3:0]  ext_addr;
    logic [10:0] ext_data;
    // source current in mA per code, lowest code first
    localparam logic [9:0] MA_TAB [16] = '{10'h00a, 10'h01e, 10'h03c, 10'h050, 10'h078,
        10'h08c, 10'h0aa, 10'h0be, 10'h104, 10'h14a, 10'h172, 10'h1b8, 10'h23a, 10'h2a8,
        10'h334, 10'h3e8};
    gdhs_drive_t drv;
    logic [9:0]  prev_ma;
    int          n_mismatch = 0, samples_checked = 0;
    gdhs_host_model gdhs_host_model_i (.i_clk(i_clk), .o_req(req));
    gdhs_config_lock gdhs_config_lock_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_ext_wr(ext_wr), .o_ext_addr(ext_addr),
        .o_ext_data(ext_data), .o_locked(locked), .o_clear_faults(clr), .o_drive(drv));
    initial forever #10 i_clk = ~i_clk;
    task automatic chk(input string n, input logic [10:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        gdhs_host_model_i.put(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [10:0] e);
        gdhs_host_model_i.put(1'b0, 1'b1, a, 11'h000);
        chk("rvalid", 11'h001, {10'h000, rvalid});
        chk("rdata", e, rdata);
    endtask
    task automatic rd3(input logic [10:0] e);
        rd(HS_CFG_ADDR, e);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_clk);
        i_sys_rst = 0;
        rd3(11'h3ff);
        chk("src_ma", 11'h3e8, {1'b0, drv.src_ma});
        wr(HS_CFG_ADDR, 11'h1a5);
        rd3(11'h3a5);
        wr(4'h5, 11'h123);
        chk("ext_wr", 11'h001, {10'h000, ext_wr});
        chk("ext_addr", 11'h005, {7'h00, ext_addr});
        chk("ext_data", 11'h123, ext_data);
        rd(4'h5, 11'h000);
        $display("test unlocked done");
        wr(HS_CFG_ADDR, 11'h6ab);
        chk("locked", 11'h001, {10'h000, locked});
        wr(HS_CFG_ADDR, 11'h155);
        rd3(11'h6ab);
        wr(4'h5, 11'h0aa);
        chk("ext_wr", 11'h000, {10'h000, ext_wr});
        chk("ext_data", 11'h123, ext_data);
        wr(DRV_CTRL_ADDR, 11'h7fe);
        chk("brake", 11'h001, {10'h000, drv.brake});
        chk("coast", 11'h001, {10'h000, drv.coast});
        chk("clear", 11'h000, {10'h000, clr});
        rd(DRV_CTRL_ADDR, 11'h006);
        wr(DRV_CTRL_ADDR, 11'h001);
        chk("clear", 11'h001, {10'h000, clr});
        @(negedge i_clk);
        chk("clear", 11'h000, {10'h000, clr});
        chk("coast", 11'h000, {10'h000, drv.coast});
        wr(HS_CFG_ADDR, 11'h300);
        rd3(11'h3ab);
        wr(DRV_CTRL_ADDR, 11'h7f8);
        rd(DRV_CTRL_ADDR, 11'h7f8);
        wr(4'h6, 11'h456);
        chk("ext_wr", 11'h001, {10'h000, ext_wr});
        chk("ext_data", 11'h456, ext_data);
        $display("test lock done");
        for (int c = 0; c < 16; c++) begin
            wr(HS_CFG_ADDR, {3'h3, c[3:0], 4'h0});
            chk("src_ma_tab", {1'b0, MA_TAB[c]}, {1'b0, drv.src_ma});
            if (c == 0)
                chk("src_ma", 11'h00a, {1'b0, drv.src_ma});
            else
                chk("src_ma_up", 11'h001, {10'h000, drv.src_ma > prev_ma});
            prev_ma = drv.src_ma;
        end
        $display("test table done");
        wr(HS_CFG_ADDR, 11'h600);
        chk("locked", 11'h001, {10'h000, locked});
        i_sys_rst = 1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 0;
        rd3(11'h3ff);
        chk("locked", 11'h000, {10'h000, locked});
        $display("test reset done");
        tally_and_finish;
    end
    initial begin
        repeat (3000) @(posedge i_clk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
